/* File: pkg/bridge_memory_window_consts.svh */
// Purpose: Offsets, field positions and reset values of the memory windows.
// Assumes: Byte offsets on the configuration bus, one 32-bit word each.
// Notes:   Definitions only.
// Contract
// [R1] Low nibbles of memory bottom and top fields read zero, reset zero.
// [R2] Bits 15:4 hold bottom address 31:20; bottom low twenty bits zero.
// [R3] Bits 31:20 hold top address 31:20; top low twenty bits ones.
// [R4] Memory bottom and top decide forwarding of memory transactions.
// [R5] Prefetch low nibbles read code 0001, meaning 64-bit addressing.
// [R6] Prefetch bits 15:4 hold bottom address 31:20; low bits zero.
// [R7] Prefetch bits 31:20 hold top address 31:20; low bits ones.
// [R8] Writable word holds prefetch bottom address 63:32, reset zero.
// [R9] Prefetch bottom and top decide forwarding of memory reads, writes.
// [R10] Writable word holds prefetch top address 63:32, reset zero.
// [R11] Hit when bottom <= address <= top; prefetch compares 64 bits.
`ifndef BRIDGE_MEMORY_WINDOW_CONSTS_SVH
`define BRIDGE_MEMORY_WINDOW_CONSTS_SVH
`define BMW_OFF_MEM       8'h20
`define BMW_OFF_PREF      8'h24
`define BMW_OFF_PREF_BHI  8'h28
`define BMW_OFF_PREF_THI  8'h2c
`define BMW_WORD_MASK     8'hfc
`define BMW_BOT_LSB       4
`define BMW_BOT_MSB       15
`define BMW_TOP_LSB       20
`define BMW_TOP_MSB       31
`define BMW_FIELD_RST     12'h000
`define BMW_UPPER_RST     32'h0000_0000
`define BMW_ADDR_CODE     4'h1
`define BMW_MEM_NIBBLE    4'h0
`define BMW_LOW20_ZERO    20'h00000
`define BMW_LOW20_ONES    20'hfffff
`endif

/* File: pkg/bridge_memory_window_pkg.sv */
// Purpose: Types shared by the memory window decoder.
// Assumes: Nothing beyond the constants header.
// Notes:   Types only.
`default_nettype none
package bridge_memory_window_pkg;
	typedef logic [31:0] word_t;
	typedef logic [11:0] field12_t;
	typedef logic [63:0] addr64_t;
	typedef logic [7:0]  cfg_addr_t;
	typedef logic [3:0]  byte_en_t;
endpackage
`default_nettype wire

/* File: rtl/bridge_memory_window_decode.sv */
// Purpose: Memory and prefetchable window registers and the hit decode.
// Assumes: Avalon-MM slave, byte addresses, one request at a time.
// Notes:   Waitrequest drops for one cycle, one edge after the request.
`include "bridge_memory_window_consts.svh"
`default_nettype none
module bridge_memory_window_decode (
	input  wire logic                                i_ref_clk,
	input  wire logic                                i_rst_n,
	input  wire logic                                i_clk_en,
	input  wire bridge_memory_window_pkg::cfg_addr_t i_address,
	input  wire logic                                i_read,
	input  wire logic                                i_write,
	input  wire bridge_memory_window_pkg::word_t     i_writedata,
	input  wire bridge_memory_window_pkg::byte_en_t  i_byteenable,
	output logic                                     o_waitrequest,
	output bridge_memory_window_pkg::word_t          o_readdata,
	input  wire bridge_memory_window_pkg::addr64_t   i_txn_addr,
	output logic                                     o_mem_hit,
	output logic                                     o_pref_hit
);
	import bridge_memory_window_pkg::*;

	field12_t  mem_bot_r;
	field12_t  mem_top_r;
	field12_t  pref_bot_r;
	field12_t  pref_top_r;
	word_t     pref_bot_hi_r;
	word_t     pref_top_hi_r;
	word_t     wmask;
	word_t     rd_nxt;
	word_t     mem_word;
	word_t     pref_word;
	word_t     mem_merge;
	word_t     pref_merge;
	word_t     bhi_merge;
	word_t     thi_merge;
	cfg_addr_t word_addr;
	logic      req;
	logic      commit_wr;
	logic      mem_hit_nxt;
	logic      pref_hit_nxt;
	addr64_t   mem_bot_full;
	addr64_t   mem_top_full;
	addr64_t   pref_bot_full;
	addr64_t   pref_top_full;

	assign word_addr = i_address & `BMW_WORD_MASK;
	assign req       = i_read | i_write;
	// A write lands only on the edge where the master sees waitrequest low.
	assign commit_wr = i_clk_en & i_write & ~o_waitrequest;

	always_comb begin
		for (int b = 0; b < 4; b++) begin
			wmask[8*b +: 8] = {8{i_byteenable[b]}};
		end
	end

	assign mem_word  = {mem_top_r, `BMW_MEM_NIBBLE,
		mem_bot_r, `BMW_MEM_NIBBLE}; // [R1]
	assign pref_word = {pref_top_r, `BMW_ADDR_CODE,
		pref_bot_r, `BMW_ADDR_CODE}; // [R5]

	assign mem_merge  = (mem_word & ~wmask) | (i_writedata & wmask);
	assign pref_merge = (pref_word & ~wmask) | (i_writedata & wmask);
	assign bhi_merge  = (pref_bot_hi_r & ~wmask) | (i_writedata & wmask);
	assign thi_merge  = (pref_top_hi_r & ~wmask) | (i_writedata & wmask);

	// Bus handshake: one cycle to accept, one cycle with waitrequest low.
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_waitrequest <= 1'b1;
		end else if (i_clk_en) begin
			o_waitrequest <= ~(req & o_waitrequest);
		end
	end

	always_comb begin
		unique case (word_addr)
			`BMW_OFF_MEM:      rd_nxt = mem_word;
			`BMW_OFF_PREF:     rd_nxt = pref_word;
			`BMW_OFF_PREF_BHI: rd_nxt = pref_bot_hi_r;
			`BMW_OFF_PREF_THI: rd_nxt = pref_top_hi_r;
			default:           rd_nxt = '0;
		endcase
	end

	// Read data is caught on the accept edge and stands while wait is low.
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_readdata <= '0;
		end else if (i_clk_en && i_read && o_waitrequest) begin
			o_readdata <= rd_nxt;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			mem_bot_r <= `BMW_FIELD_RST;
			mem_top_r <= `BMW_FIELD_RST;
		end else if (commit_wr && word_addr == `BMW_OFF_MEM) begin
			mem_bot_r <= mem_merge[`BMW_BOT_MSB:`BMW_BOT_LSB]; // [R2]
			mem_top_r <= mem_merge[`BMW_TOP_MSB:`BMW_TOP_LSB]; // [R3]
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			pref_bot_r <= `BMW_FIELD_RST;
			pref_top_r <= `BMW_FIELD_RST;
		end else if (commit_wr && word_addr == `BMW_OFF_PREF) begin
			pref_bot_r <= pref_merge[`BMW_BOT_MSB:`BMW_BOT_LSB]; // [R6]
			pref_top_r <= pref_merge[`BMW_TOP_MSB:`BMW_TOP_LSB]; // [R7]
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			pref_bot_hi_r <= `BMW_UPPER_RST;
		end else if (commit_wr && word_addr == `BMW_OFF_PREF_BHI) begin
			pref_bot_hi_r <= bhi_merge; // [R8]
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			pref_top_hi_r <= `BMW_UPPER_RST;
		end else if (commit_wr && word_addr == `BMW_OFF_PREF_THI) begin
			pref_top_hi_r <= thi_merge; // [R10]
		end
	end

	// The plain window sits below 4 GB, so its upper half is zero.
	assign mem_bot_full  = {`BMW_UPPER_RST, mem_bot_r,
		`BMW_LOW20_ZERO}; // [R2]
	assign mem_top_full  = {`BMW_UPPER_RST, mem_top_r,
		`BMW_LOW20_ONES}; // [R3]
	assign pref_bot_full = {pref_bot_hi_r, pref_bot_r,
		`BMW_LOW20_ZERO}; // [R6] [R8]
	assign pref_top_full = {pref_top_hi_r, pref_top_r,
		`BMW_LOW20_ONES}; // [R7] [R10]

	// A bottom above the top gives an empty window, which is how
	// software switches a window off.
	assign mem_hit_nxt  = (i_txn_addr >= mem_bot_full) &&
		(i_txn_addr <= mem_top_full); // [R4] [R11]
	assign pref_hit_nxt = (i_txn_addr >= pref_bot_full) &&
		(i_txn_addr <= pref_top_full); // [R9] [R11]

	// Hits are registered, so they trail the address by one edge.
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_mem_hit  <= 1'b0;
			o_pref_hit <= 1'b0;
		end else if (i_clk_en) begin
			o_mem_hit  <= mem_hit_nxt; // [R4]
			o_pref_hit <= pref_hit_nxt; // [R9]
		end
	end

	mem_low_zero_a: assert property ( // [R1]
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_clk_en && i_read && o_waitrequest &&
			word_addr == `BMW_OFF_MEM)
		|=> (o_readdata[3:0] == 4'h0 && o_readdata[19:16] == 4'h0)
	) else $error("Memory window low nibbles not zero.");

	mem_bot_wr_a: assert property ( // [R2]
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(commit_wr && word_addr == `BMW_OFF_MEM &&
			i_byteenable == 4'hf)
		|=> (mem_bot_r == $past(i_writedata[15:4]) &&
			mem_bot_full[19:0] == 20'h00000)
	) else $error("Memory bottom write not stored.");

	mem_top_wr_a: assert property ( // [R3]
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(commit_wr && word_addr == `BMW_OFF_MEM &&
			i_byteenable == 4'hf)
		|=> (mem_top_r == $past(i_writedata[31:20]) &&
			mem_top_full[19:0] == 20'hfffff)
	) else $error("Memory top write not stored.");

	mem_hit_in_a: assert property ( // [R4]
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_clk_en && i_txn_addr[63:32] == 32'h0 &&
			i_txn_addr[31:20] >= mem_bot_r &&
			i_txn_addr[31:20] <= mem_top_r)
		|=> o_mem_hit
	) else $error("Address inside memory window missed.");

	mem_hit_out_a: assert property ( // [R11]
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_clk_en && (i_txn_addr[63:32] != 32'h0 ||
			i_txn_addr[31:20] < mem_bot_r ||
			i_txn_addr[31:20] > mem_top_r))
		|=> !o_mem_hit
	) else $error("Address outside memory window hit.");

	pref_code_a: assert property ( // [R5]
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_clk_en && i_read && o_waitrequest &&
			word_addr == `BMW_OFF_PREF)
		##1 !o_waitrequest
		|-> (o_readdata[3:0] == 4'h1 && o_readdata[19:16] == 4'h1)
	) else $error("Prefetch addressing code not 0001.");

	pref_bot_wr_a: assert property ( // [R6]
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(commit_wr && word_addr == `BMW_OFF_PREF &&
			i_byteenable[1:0] == 2'b11)
		|=> (pref_bot_r == $past(i_writedata[15:4]))
	) else $error("Prefetch bottom write not stored.");

	pref_top_wr_a: assert property ( // [R7]
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(commit_wr && word_addr == `BMW_OFF_PREF &&
			i_byteenable[3:2] == 2'b11)
		|=> (pref_top_r == $past(i_writedata[31:20]))
	) else $error("Prefetch top write not stored.");

	pref_bhi_wr_a: assert property ( // [R8]
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(commit_wr && word_addr == `BMW_OFF_PREF_BHI &&
			i_byteenable == 4'hf)
		|=> (pref_bot_hi_r == $past(i_writedata))
	) else $error("Prefetch bottom upper word not stored.");

	pref_thi_wr_a: assert property ( // [R10]
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(commit_wr && word_addr == `BMW_OFF_PREF_THI &&
			i_byteenable == 4'hf)
		|=> (pref_top_hi_r == $past(i_writedata))
	) else $error("Prefetch top upper word not stored.");

	pref_hit_in_a: assert property ( // [R9]
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_clk_en &&
			i_txn_addr[63:20] >= {pref_bot_hi_r, pref_bot_r} &&
			i_txn_addr[63:20] <= {pref_top_hi_r, pref_top_r})
		|=> o_pref_hit
	) else $error("Address inside prefetch window missed.");

	pref_hit_out_a: assert property ( // [R11]
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_clk_en &&
			(i_txn_addr[63:20] < {pref_bot_hi_r, pref_bot_r} ||
			i_txn_addr[63:20] > {pref_top_hi_r, pref_top_r}))
		|=> !o_pref_hit
	) else $error("Address outside prefetch window hit.");

	reset_vals_a: assert property ( // [R1] [R8] [R10]
		@(posedge i_ref_clk)
		$past(!i_rst_n) && i_rst_n
		|-> (mem_bot_r == 12'h0 && mem_top_r == 12'h0 &&
			pref_bot_hi_r == 32'h0 && pref_top_hi_r == 32'h0 &&
			o_waitrequest)
	) else $error("Register reset value wrong.");

	bus_ack_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_clk_en && req && o_waitrequest)
		|=> !o_waitrequest ##1 (o_waitrequest || !i_clk_en)
	) else $error("Waitrequest did not pulse for one cycle.");

	unmapped_rd_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_clk_en && i_read && o_waitrequest &&
			word_addr > `BMW_OFF_PREF_THI)
		|=> (o_readdata == 32'h0)
	) else $error("Unmapped read returned data.");

	freeze_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		!i_clk_en |=> ($stable(o_waitrequest) && $stable(o_mem_hit) &&
			$stable(o_pref_hit) && $stable(mem_bot_r))
	) else $error("State moved while the clock enable was low.");

	// Clock enable low is a full stall; no field may creep meanwhile.
	freeze_regs_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		!i_clk_en |=> ($stable(o_readdata) && $stable(mem_top_r) &&
			$stable(pref_bot_r) && $stable(pref_top_r) &&
			$stable(pref_bot_hi_r) && $stable(pref_top_hi_r))
	) else $error("Field moved while the clock enable was low.");

	hit_reset_a: assert property ( // [R11]
		@(posedge i_ref_clk)
		$past(!i_rst_n) && i_rst_n |-> (!o_mem_hit && !o_pref_hit)
	) else $error("Hit flag set straight after reset.");

	// Read data must not move while the master is still taking it.
	rd_hold_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_clk_en && !o_waitrequest) |=> $stable(o_readdata)
	) else $error("Read data moved during the answer cycle.");

	idle_wait_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_clk_en && !req && o_waitrequest) |=> o_waitrequest
	) else $error("Waitrequest dropped with no request.");

	// The accept edge must leave the four bottom and top fields alone; only the answer
	// edge may write, so a master that gives up early changes nothing.
	accept_no_wr_a: assert property ( // [R2] [R3]
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_clk_en && i_write && o_waitrequest)
		|=> ($stable(mem_bot_r) && $stable(mem_top_r) &&
			$stable(pref_bot_r) && $stable(pref_top_r))
	) else $error("Field written before the answer cycle.");

	mem_top_keep_a: assert property ( // [R3]
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(commit_wr && word_addr == `BMW_OFF_MEM &&
			i_byteenable[3:2] == 2'b00)
		|=> $stable(mem_top_r)
	) else $error("Memory top changed by a masked write.");

	unmapped_wr_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(commit_wr && word_addr > `BMW_OFF_PREF_THI)
		|=> ($stable(mem_bot_r) && $stable(mem_top_r) &&
			$stable(pref_bot_r) && $stable(pref_top_r) &&
			$stable(pref_bot_hi_r) && $stable(pref_top_hi_r))
	) else $error("Unmapped write changed a field.");

	mem_read_a: assert property ( // [R2] [R3]
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_clk_en && i_read && o_waitrequest &&
			word_addr == `BMW_OFF_MEM)
		|=> (o_readdata[15:4] == $past(mem_bot_r) &&
			o_readdata[31:20] == $past(mem_top_r))
	) else $error("Memory window fields read wrong.");

	bhi_read_a: assert property ( // [R8]
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_clk_en && i_read && o_waitrequest &&
			word_addr == `BMW_OFF_PREF_BHI)
		|=> (o_readdata == $past(pref_bot_hi_r))
	) else $error("Prefetch bottom upper word read wrong.");

	thi_read_a: assert property ( // [R10]
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_clk_en && i_read && o_waitrequest &&
			word_addr == `BMW_OFF_PREF_THI)
		|=> (o_readdata == $past(pref_top_hi_r))
	) else $error("Prefetch top upper word read wrong.");

endmodule
`default_nettype wire

/* File: verification/cfg_master.sv */
// Purpose: Configuration software model driving Avalon-MM accesses.
// Assumes: Caller enters a task just after a rising clock edge.
// Notes:   A request is held until waitrequest is seen low.
`default_nettype none
module cfg_master (
	input  wire logic        i_ref_clk,
	input  wire logic        i_waitrequest,
	input  wire logic [31:0] i_readdata,
	output var logic  [7:0]  o_address,
	output var logic         o_read,
	output var logic         o_write,
	output var logic  [31:0] o_writedata,
	output var logic  [3:0]  o_byteenable
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_address = 8'h00;
		o_read = 1'b0;
		o_write = 1'b0;
		o_writedata = 32'h0;
		o_byteenable = 4'hf;
	end
	// No release here, so a following access may start back to back.
	task automatic access(input logic wr, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] be,
		output logic [31:0] q);
		o_address <= a;
		o_write <= wr;
		o_read <= !wr;
		o_writedata <= d;
		o_byteenable <= be;
		do @(posedge i_ref_clk); while (i_waitrequest !== 1'b0);
		q = i_readdata;
	endtask
	task automatic idle();
		o_read <= 1'b0;
		o_write <= 1'b0;
		@(posedge i_ref_clk);
	endtask
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// Purpose: Self-checking bench for the memory window registers and decode.
// Assumes: Waitrequest low marks completion; hits lag the address by one edge.
// Notes:   Clock enable drops once for three edges, to check that the memory hit flag holds.
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_ref_clk = 1'b0;
	logic        i_rst_n = 1'b0;
	logic        clk_en = 1'b1;
	logic [7:0]  address;
	logic        rd;
	logic        wr;
	logic [31:0] wdata;
	logic [3:0]  be;
	logic        o_waitrequest;
	logic [31:0] o_readdata;
	logic [63:0] i_txn_addr = 64'h0;
	logic        o_mem_hit;
	logic        o_pref_hit;
	int          miscompares = 0;
	int          num_checks = 0;
	logic [31:0] q;

	bridge_memory_window_decode u_bridge_memory_window_decode (
		.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_clk_en(clk_en),
		.i_address(address), .i_read(rd), .i_write(wr),
		.i_writedata(wdata), .i_byteenable(be),
		.o_waitrequest(o_waitrequest), .o_readdata(o_readdata),
		.i_txn_addr(i_txn_addr), .o_mem_hit(o_mem_hit),
		.o_pref_hit(o_pref_hit));
	cfg_master u_cfg_master (
		.i_ref_clk(i_ref_clk), .i_waitrequest(o_waitrequest),
		.i_readdata(o_readdata), .o_address(address), .o_read(rd),
		.o_write(wr), .o_writedata(wdata), .o_byteenable(be));

	initial begin
		forever #12.5 i_ref_clk = ~i_ref_clk;
	end

	task automatic check(input string name, input logic [63:0] seen,
		input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wrreg(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] m);
		u_cfg_master.access(1'b1, a, d, m, q);
	endtask
	task automatic rdreg(input logic [7:0] a, input logic [31:0] exp);
		u_cfg_master.access(1'b0, a, 32'h0, 4'hf, q);
		check("readdata", {32'h0, q}, {32'h0, exp});
	endtask
	task automatic hit(input logic [63:0] a, input logic em,
		input logic ep);
		i_txn_addr <= a;
		@(posedge i_ref_clk);
		@(posedge i_ref_clk);
		check("mem_hit", {63'h0, o_mem_hit}, {63'h0, em});
		check("pref_hit", {63'h0, o_pref_hit}, {63'h0, ep});
	endtask
	task automatic conclude();
		if (miscompares == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		#(25.0 * 4000);
		miscompares++;
		conclude();
	end

	initial begin
		repeat (20) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		@(posedge i_ref_clk);
		rdreg(8'h20, 32'h0000_0000);
		rdreg(8'h24, 32'h0001_0001);
		rdreg(8'h28, 32'h0000_0000);
		rdreg(8'h2c, 32'h0000_0000);
		u_cfg_master.idle();
		hit(64'h0000_0000_000f_ffff, 1'b1, 1'b1);
		hit(64'h0000_0000_0010_0000, 1'b0, 1'b0);
		wrreg(8'h20, 32'hffff_ffff, 4'hf);
		rdreg(8'h20, 32'hfff0_fff0);
		wrreg(8'h20, 32'h0000_0000, 4'h1);
		rdreg(8'h20, 32'hfff0_ff00);
		wrreg(8'h24, 32'hffff_ffff, 4'hf);
		rdreg(8'h24, 32'hfff1_fff1);
		wrreg(8'h30, 32'hffff_ffff, 4'hf);
		rdreg(8'h30, 32'h0000_0000);
		wrreg(8'h20, 32'h1240_1230, 4'hf);
		wrreg(8'h24, 32'h0001_8001, 4'hf);
		wrreg(8'h28, 32'h0000_0001, 4'hf);
		wrreg(8'h2c, 32'h0000_0002, 4'hf);
		rdreg(8'h28, 32'h0000_0001);
		rdreg(8'h2c, 32'h0000_0002);
		u_cfg_master.idle();
		hit(64'h0000_0000_1230_0000, 1'b1, 1'b0);
		clk_en <= 1'b0;
		i_txn_addr <= 64'h0000_0000_1250_0000;
		repeat (3) @(posedge i_ref_clk);
		check("frozen_hit", {63'h0, o_mem_hit}, 64'h1);
		clk_en <= 1'b1;
		hit(64'h0000_0000_1250_0000, 1'b0, 1'b0);
		hit(64'h0000_0000_122f_ffff, 1'b0, 1'b0);
		hit(64'h0000_0000_124f_ffff, 1'b1, 1'b0);
		hit(64'h0000_0000_1250_0000, 1'b0, 1'b0);
		hit(64'h0000_0001_1230_0000, 1'b0, 1'b0);
		hit(64'h0000_0001_7fff_ffff, 1'b0, 1'b0);
		hit(64'h0000_0001_8000_0000, 1'b0, 1'b1);
		hit(64'h0000_0002_000f_ffff, 1'b0, 1'b1);
		hit(64'h0000_0002_0010_0000, 1'b0, 1'b0);
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		@(posedge i_ref_clk);
		rdreg(8'h20, 32'h0000_0000);
		rdreg(8'h24, 32'h0001_0001);
		rdreg(8'h28, 32'h0000_0000);
		rdreg(8'h2c, 32'h0000_0000);
		u_cfg_master.idle();
		conclude();
	end
endmodule
`default_nettype wire
